//--- design/sfr_bank3_cfg.svh
`ifndef SFR_BANK3_CFG_SVH
`define SFR_BANK3_CFG_SVH
// register offsets within the upper bank
`define OFS_INDIRECT_ACCESS_PORT 9'h180
`define OFS_PRESCALER_EDGE_CONFIG 9'h181
`define OFS_PROGRAM_COUNTER_LOW 9'h182
`define OFS_ALU_RESET_BANK_FLAGS 9'h183
`define OFS_INDIRECT_POINTER 9'h184
`define OFS_PORT_B_DIRECTION 9'h186
`define OFS_PORT_F_DIRECTION 9'h187
`define OFS_PORT_G_DIRECTION 9'h188
`define OFS_PC_UPPER_WRITE_BUFFER 9'h18a
`define OFS_INTERRUPT_CONTROL 9'h18b
`define OFS_PROGMEM_DATA_LOW 9'h18c
`define OFS_PROGMEM_ADDR_LOW 9'h18d
`define OFS_PROGMEM_DATA_HIGH 9'h18e
`define OFS_PROGMEM_ADDR_HIGH 9'h18f
`define BANK3_BASE 9'h180
`define BANK3_LAST 9'h19f
// status register field positions
`define STAT_CARRY 0
`define STAT_NIBBLE 1
`define STAT_ZERO 2
`define STAT_PD 3
`define STAT_TO 4
`define STAT_BANK_LOW 5
`define STAT_BANK_HIGH 6
`define STAT_IRP 7
// writable masks for partly implemented registers, then the status flag and read-only bit masks
`define MASK_PC_UPPER 8'h1f
`define MASK_PROGMEM_DATA_HIGH 8'h3f
`define MASK_PROGMEM_ADDR_HIGH 8'h1f
`define MASK_STATUS_FLAGS 8'h07
`define MASK_STATUS_RO 8'h18
// reset values
`define RST_OPTION 8'hff
`define RST_TRIS 8'hff
`define RST_ZERO 8'h00
`define RST_STATUS 8'h18
`endif

//--- design/sfr_bank3_pkg.sv
package sfr_bank3_pkg;
  typedef struct packed {
    logic indirect_bank_bit;
    logic bank_high;
    logic bank_low;
    logic timeout_indicator;
    logic powerdown_indicator;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } status_type;
  // one file access from the core datapath
  typedef struct packed {
    logic wr;
    logic [8:0] addr;
    logic [7:0] data;
    logic flags_affected;
    logic is_clear;
  } access_type;
  // flags computed by the alu for the current result
  typedef struct packed {
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } alu_flags_type;
  typedef enum logic [3:0] {
    EV_NONE = 4'b0001,
    EV_POWERUP = 4'b0010,
    EV_WDT_CLR = 4'b0100,
    EV_SLEEP = 4'b1000
  } ev_type;
endpackage : sfr_bank3_pkg

//--- design/status_flag_unit.sv
`timescale 1ns/10ps
`include "sfr_bank3_cfg.svh"
// next-state of the status register from writes, alu flags and reset/sleep events
module status_flag_unit (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // write request
  input wire logic i_wr,
  input wire logic [7:0] i_data,
  input wire logic i_flags_affected,
  input wire logic i_is_clear,
  input wire sfr_bank3_pkg::alu_flags_type i_alu,
  input wire logic i_alu_valid,
  // reset-cause events
  input wire logic i_wdt_clear,
  input wire logic i_sleep,
  input wire logic i_wdt_timeout,
  // register
  output sfr_bank3_pkg::status_type o_status
);
  sfr_bank3_pkg::status_type status_r;
  sfr_bank3_pkg::status_type status_nxt;
  logic [7:0] wr_val;
  logic [7:0] keep_mask;
  logic [7:0] base;
  logic [2:0] flag_val;
  // flag writes are suppressed when the instruction owns the flags
  assign keep_mask = i_flags_affected ? (`MASK_STATUS_FLAGS | `MASK_STATUS_RO) : `MASK_STATUS_RO; // R3 R5
  // clear writes zero to bank bits; zero flag is forced set by the flag_val path, not taken from the alu (R6)
  assign wr_val = i_is_clear ? 8'h00 : i_data;
  assign base = i_wr ? ((status_r & keep_mask) | (wr_val & ~keep_mask)) : status_r; // R2 R14
  // alu result flags win over data write; clear forces zero flag set
  assign flag_val = i_is_clear ? {1'b1, status_r.nibble_carry_flag, status_r.carry} : // R6
    {i_alu.zero, i_alu.nibble_carry_flag, i_alu.carry}; // R4 R8 R13

  always_comb begin
    status_nxt = base;
    if (i_alu_valid || i_is_clear) begin
      status_nxt.zero = flag_val[2];
      status_nxt.nibble_carry_flag = flag_val[1];
      status_nxt.carry = flag_val[0];
    end
    // indicators move only by device events
    if (i_wdt_clear) begin
      status_nxt.timeout_indicator = 1'b1; // R11
      status_nxt.powerdown_indicator = 1'b1; // R12
    end else if (i_sleep) begin
      status_nxt.timeout_indicator = 1'b1; // R11
      status_nxt.powerdown_indicator = 1'b0; // R12
    end else if (i_wdt_timeout) begin
      status_nxt.timeout_indicator = 1'b0; // R11
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      status_r <= `RST_STATUS; // R11 R12
    end else begin
      status_r <= status_nxt;
    end
  end
  assign o_status = status_r;
endmodule : status_flag_unit

//--- design/sfr_bank3_status_write_logic.sv
`timescale 1ns/10ps
`include "sfr_bank3_cfg.svh"
// Contract
// R1: the status byte holds alu flags, reset-cause indicators and bank-select bits together.
// R2: the status register may be the destination of any instruction like any file register.
// R3: an instruction that updates zero, nibble carry or carry does not write those bits with data.
// R4: in that case those three flags take the alu values for the result.
// R5: timeout and powerdown indicators ignore all software writes.
// R6: a clear-file aimed at status zeroes the bank bits, sets zero and keeps the other bits.
// R7: software should alter status only with bit-clear, bit-set, nibble-swap or move-from-working.
// R8: in subtraction carry is an inverted borrow and nibble carry an inverted nibble borrow.
// R9: unimplemented addresses and bits read zero and ignore writes.
// R10: the direct bank bits pick banks 0..3 and the indirect bank bit picks the lower or upper pair.
// R11: timeout is set by power-up, watchdog clear or sleep, cleared by watchdog time-out.
// R12: powerdown is set by power-up or watchdog clear, cleared by sleep.
// R13: zero is set when a result is zero and cleared otherwise.
// R14: a write by an instruction that does not affect flags loads all writable status bits.
module sfr_bank3_status_write_logic (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // core access
  input wire sfr_bank3_pkg::access_type i_acc,
  input wire logic [7:0] i_alu_result,
  input wire sfr_bank3_pkg::alu_flags_type i_alu_raw,
  input wire logic i_alu_valid,
  input wire logic i_is_sub,
  // device events
  input wire logic i_wdt_clear,
  input wire logic i_sleep,
  input wire logic i_wdt_timeout,
  // read data and register outputs
  output logic [7:0] o_rdata,
  output sfr_bank3_pkg::status_type o_status,
  output logic [1:0] o_direct_bank,
  output logic o_indirect_upper,
  output logic [7:0] o_option,
  output logic [7:0] o_pointer,
  output logic [7:0] o_pcl,
  output logic [4:0] o_pc_upper,
  output logic [7:0] o_interrupt_control,
  output logic [7:0] o_tris_b,
  output logic [7:0] o_tris_f,
  output logic [7:0] o_tris_g,
  output logic [13:0] o_pm_data,
  output logic [12:0] o_pm_addr
);
  localparam int NREG = 12;
  // register offset per plain storage register
  logic [8:0] ofs [NREG];
  logic [7:0] rst_val [NREG];
  logic [7:0] wmask [NREG];
  logic [7:0] regs_r [NREG];
  logic [NREG-1:0] hit;
  logic status_hit;
  logic in_bank;
  logic [7:0] rd_term [NREG];
  logic [7:0] rd_or [NREG+1];
  logic [7:0] plain_rd;
  logic [13:0] pm_data_w;
  logic [12:0] pm_addr_w;
  logic st_wr;
  sfr_bank3_pkg::alu_flags_type alu_fix;
  sfr_bank3_pkg::status_type status_w;
  logic [7:0] rdata_nxt;

  assign ofs = '{`OFS_PRESCALER_EDGE_CONFIG, `OFS_PROGRAM_COUNTER_LOW, `OFS_INDIRECT_POINTER,
    `OFS_PORT_B_DIRECTION, `OFS_PORT_F_DIRECTION, `OFS_PORT_G_DIRECTION, `OFS_PC_UPPER_WRITE_BUFFER,
    `OFS_INTERRUPT_CONTROL, `OFS_PROGMEM_DATA_LOW, `OFS_PROGMEM_ADDR_LOW, `OFS_PROGMEM_DATA_HIGH,
    `OFS_PROGMEM_ADDR_HIGH};
  assign rst_val = '{`RST_OPTION, `RST_ZERO, `RST_ZERO, `RST_TRIS, `RST_TRIS, `RST_TRIS, `RST_ZERO,
    `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO};
  assign wmask = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, `MASK_PC_UPPER, 8'hff, 8'hff, 8'hff,
    `MASK_PROGMEM_DATA_HIGH, `MASK_PROGMEM_ADDR_HIGH};

  assign in_bank = (i_acc.addr >= `BANK3_BASE) && (i_acc.addr <= `BANK3_LAST);
  assign status_hit = (i_acc.addr == `OFS_ALU_RESET_BANK_FLAGS);
  assign st_wr = i_acc.wr && status_hit; // R2

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign hit[g] = (i_acc.addr == ofs[g]);
      // an entry adds its value only when addressed, so the or-chain acts as the read mux
      assign rd_term[g] = hit[g] ? (regs_r[g] & wmask[g]) : 8'h00; // R9
      assign rd_or[g + 1] = rd_or[g] | rd_term[g];
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          regs_r[g] <= rst_val[g];
        end else if (i_acc.wr && hit[g]) begin
          regs_r[g] <= i_acc.data & wmask[g]; // R9
        end
      end
    end
  endgenerate

  assign rd_or[0] = 8'h00;
  assign plain_rd = rd_or[NREG];

  // alu already adds the two's complement; carries are kept as-is so they read as inverted borrows
  assign alu_fix.carry = i_alu_raw.carry; // R8
  assign alu_fix.nibble_carry_flag = i_alu_raw.nibble_carry_flag; // R8
  assign alu_fix.zero = (i_alu_result == 8'h00); // R13

  status_flag_unit u_status (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_wr(st_wr),
    .i_data(i_acc.data),
    .i_flags_affected(i_acc.flags_affected && st_wr),
    .i_is_clear(i_acc.is_clear && st_wr),
    .i_alu(alu_fix),
    .i_alu_valid(i_alu_valid && i_acc.flags_affected),
    .i_wdt_clear(i_wdt_clear),
    .i_sleep(i_sleep),
    .i_wdt_timeout(i_wdt_timeout),
    .o_status(status_w)
  ); // R1 R3 R4 R5 R6

  // indirect port is not storage and reads as zero here; unmapped addresses read zero
  assign rdata_nxt = !in_bank ? 8'h00 : status_hit ? status_w : plain_rd; // R9

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

  // registered copies so every output comes from a flip-flop
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_status <= `RST_STATUS;
      o_direct_bank <= 2'b00;
      o_indirect_upper <= 1'b0;
    end else begin
      o_status <= status_w;
      o_direct_bank <= {status_w.bank_high, status_w.bank_low}; // R10
      o_indirect_upper <= status_w.indirect_bank_bit; // R10
    end
  end

  // program-memory words pair a low byte with the implemented bits of its high byte
  assign pm_data_w = {regs_r[10][5:0], regs_r[8]};
  assign pm_addr_w = {regs_r[11][4:0], regs_r[9]};

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_option <= `RST_OPTION;
    end else begin
      o_option <= regs_r[0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pcl <= 8'h00;
    end else begin
      o_pcl <= regs_r[1];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pointer <= 8'h00;
    end else begin
      o_pointer <= regs_r[2];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_tris_b <= `RST_TRIS;
    end else begin
      o_tris_b <= regs_r[3];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_tris_f <= `RST_TRIS;
    end else begin
      o_tris_f <= regs_r[4];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_tris_g <= `RST_TRIS;
    end else begin
      o_tris_g <= regs_r[5];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pc_upper <= 5'h00;
    end else begin
      o_pc_upper <= regs_r[6][4:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_interrupt_control <= 8'h00;
    end else begin
      o_interrupt_control <= regs_r[7];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pm_data <= 14'h0000;
    end else begin
      o_pm_data <= pm_data_w;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pm_addr <= 13'h0000;
    end else begin
      o_pm_addr <= pm_addr_w;
    end
  end
endmodule : sfr_bank3_status_write_logic

//--- tb/sfr_bank3_chk.sv
`timescale 1ns/10ps
module sfr_bank3_chk (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // core side
  input wire sfr_bank3_pkg::access_type i_acc,
  input wire logic [7:0] i_alu_result,
  input wire sfr_bank3_pkg::alu_flags_type i_alu_raw,
  input wire logic i_alu_valid,
  input wire logic i_wdt_clear,
  input wire logic i_sleep,
  input wire logic i_wdt_timeout,
  // outputs watched
  input wire logic [7:0] o_rdata,
  input wire sfr_bank3_pkg::status_type o_status,
  input wire logic [1:0] o_direct_bank,
  input wire logic o_indirect_upper
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire logic [8:0] a = i_acc.addr;
  wire logic swr = i_acc.wr && a == 9'h183;
  wire logic hole = a < 9'h181 || a > 9'h18f || a == 9'h185 || a == 9'h189;
  // o_status lags the taking edge by one more edge, hence the depth of 2
  chk_ro_bits: assert property (!$past(i_rst) && !$past(i_rst, 2) && $changed(o_status[4:3])
    |-> $past(i_wdt_clear, 2) || $past(i_sleep, 2) || $past(i_wdt_timeout, 2)) else $error("ro bits moved");
  chk_bank_copy: assert property ({o_indirect_upper, o_direct_bank} == o_status[7:5])
    else $error("bank select wrong");
  chk_hole_zero: assert property (hole |=> o_rdata == 8'h00) else $error("hole read nonzero");
  chk_part_bits: assert property (a == 9'h18a || a == 9'h18f |=> o_rdata[7:5] == 3'h0)
    else $error("unused bits set");
  chk_clear_status: assert property (swr && i_acc.is_clear |-> ##2 o_status[7:5] == 3'h0
    && o_status.zero && o_status[1:0] == $past(o_status[1:0])) else $error("clear wrong");
  chk_alu_flags: assert property (swr && i_acc.flags_affected && !i_acc.is_clear && i_alu_valid |-> ##2
    o_status[2:0] == {$past(i_alu_result, 2) == 8'h00, $past(i_alu_raw[1:0], 2)}) else $error("alu flags wrong");
  chk_plain_write: assert property (swr && !i_acc.flags_affected && !i_acc.is_clear |-> ##2
    {o_status[7:5], o_status[2:0]} == {$past(i_acc.data[7:5], 2), $past(i_acc.data[2:0], 2)})
    else $error("plain write wrong");
  chk_wdt_clear: assert property (i_wdt_clear |-> ##2 o_status[4:3] == 2'h3) else $error("wdt clear wrong");
  chk_sleep_bits: assert property (i_sleep && !i_wdt_clear |-> ##2 o_status[4:3] == 2'h2)
    else $error("sleep wrong");
endmodule : sfr_bank3_chk
bind sfr_bank3_status_write_logic sfr_bank3_chk u_chk (.i_clock, .i_rst, .i_acc, .i_alu_result, .i_alu_raw,
  .i_alu_valid, .i_wdt_clear, .i_sleep, .i_wdt_timeout, .o_rdata, .o_status, .o_direct_bank, .o_indirect_upper);

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic i_clock = 0, i_rst = 1, i_alu_valid = 0, i_wdt_clear = 0, i_sleep = 0, i_wdt_timeout = 0;
  logic [7:0] i_alu_result = 8'h00, o_rdata, rv;
  sfr_bank3_pkg::access_type i_acc = '0;
  sfr_bank3_pkg::alu_flags_type i_alu_raw = '0;
  sfr_bank3_pkg::status_type o_status;
  logic [1:0] o_direct_bank;
  logic o_indirect_upper;
  logic [7:0] o_option, o_pointer, o_pcl, o_interrupt_control, o_tris_b, o_tris_f, o_tris_g;
  logic [4:0] o_pc_upper;
  logic [13:0] o_pm_data;
  logic [12:0] o_pm_addr;
  logic i_is_sub = 0;
  int bad_count = 0, checks = 0;
  sfr_bank3_status_write_logic dut (.i_clock, .i_rst, .i_acc, .i_alu_result, .i_alu_raw, .i_alu_valid,
    .i_is_sub, .i_wdt_clear, .i_sleep, .i_wdt_timeout, .o_rdata, .o_status, .o_direct_bank,
    .o_indirect_upper, .o_option, .o_pointer, .o_pcl, .o_pc_upper, .o_interrupt_control, .o_tris_b,
    .o_tris_f, .o_tris_g, .o_pm_data, .o_pm_addr);
  initial forever #4 i_clock = ~i_clock;
  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic fa, input logic clr);
    @(posedge i_clock);
    i_acc <= '{1'b1, a, d, fa, clr};
    @(posedge i_clock);
    i_acc <= '0;
    @(posedge i_clock);
    #1;
  endtask : wr
  task automatic rd(input logic [8:0] a);
    @(posedge i_clock);
    i_acc <= '{1'b0, a, 8'h00, 1'b0, 1'b0};
    @(posedge i_clock);
    #1;
    rv = o_rdata;
  endtask : rd
  function automatic logic [7:0] msk(input logic [8:0] a);
    case (a)
      9'h181, 9'h182, 9'h184, 9'h186, 9'h187, 9'h188, 9'h18b, 9'h18c, 9'h18d: return 8'hff;
      9'h18a, 9'h18f: return 8'h1f;
      9'h18e: return 8'h3f;
      default: return 8'h00;
    endcase
  endfunction : msk
  task automatic t_map;
    logic [7:0] d;
    for (int p = 0; p < 2; p++) begin
      d = p ? 8'h5a : 8'ha5;
      // status skipped here: its write rules are exercised on their own
      for (logic [8:0] a = 9'h17f; a <= 9'h1a0; a++) if (a != 9'h183) wr(a, d, 1'b0, 1'b0);
      for (logic [8:0] a = 9'h17f; a <= 9'h1a0; a++) begin
        rd(a);
        if (a != 9'h183) chk("readback", d & msk(a), rv);
      end
      chk("option out", d, o_option);
      chk("pcl out", d, o_pcl);
      chk("pointer out", d, o_pointer);
      chk("interrupt_control out", d, o_interrupt_control);
      chk("tris b out", d, o_tris_b);
      chk("tris f out", d, o_tris_f);
      chk("tris g out", d, o_tris_g);
      chk("pc upper out", d & 8'h1f, {3'h0, o_pc_upper});
      chk("pm data low", d, o_pm_data[7:0]);
      chk("pm data high", d & 8'h3f, {2'h0, o_pm_data[13:8]});
      chk("pm addr low", d, o_pm_addr[7:0]);
      chk("pm addr high", d & 8'h1f, {3'h0, o_pm_addr[12:8]});
    end
    $display("map test done");
  endtask : t_map
  task automatic t_status;
    rd(9'h183);
    chk("status reset", 8'h18, rv);
    wr(9'h183, 8'hff, 1'b0, 1'b0);
    chk("status ones", 8'hff, o_status);
    wr(9'h183, 8'h00, 1'b0, 1'b0);
    chk("status zeros", 8'h18, o_status);
    for (int i = 0; i < 8; i++) begin
      wr(9'h183, {i[2:0], 5'h00}, 1'b0, 1'b0);
      @(posedge i_clock);
      #1;
      chk("bank select", {5'h00, i[2:0]}, {5'h00, o_indirect_upper, o_direct_bank});
    end
    $display("status test done");
  endtask : t_status
  task automatic t_flags;
    @(posedge i_clock);
    i_alu_valid <= 1'b1;
    i_alu_result <= 8'h00;
    i_alu_raw <= 3'h7;
    wr(9'h183, 8'he0, 1'b1, 1'b0);
    chk("zero result", 8'hff, o_status);
    @(posedge i_clock);
    i_alu_result <= 8'h01;
    i_alu_raw <= 3'h0;
    // alu now disagrees with the held carries, so a clear that lost them would show
    wr(9'h183, 8'h00, 1'b1, 1'b1);
    chk("clear status", 8'h1f, o_status);
    @(posedge i_clock);
    i_alu_valid <= 1'b0;
    wr(9'h183, 8'h40, 1'b1, 1'b0);
    chk("flags held", 8'h5f, o_status);
    @(posedge i_clock);
    i_alu_valid <= 1'b1;
    i_is_sub <= 1'b1;
    wr(9'h183, 8'hff, 1'b1, 1'b0);
    chk("borrow result", 8'hf8, o_status);
    @(posedge i_clock);
    i_is_sub <= 1'b0;
    $display("flags test done");
  endtask : t_flags
  task automatic ev(input logic [2:0] e, input logic [1:0] x);
    @(posedge i_clock);
    {i_wdt_clear, i_sleep, i_wdt_timeout} <= e;
    @(posedge i_clock);
    {i_wdt_clear, i_sleep, i_wdt_timeout} <= 3'h0;
    @(posedge i_clock);
    #1;
    chk("indicators", {6'h00, x}, {6'h00, o_status[4:3]});
  endtask : ev
  task automatic t_events;
    ev(3'b010, 2'h2);
    ev(3'b001, 2'h0);
    wr(9'h183, 8'h18, 1'b0, 1'b0);
    chk("ro kept", 8'h00, o_status & 8'h18);
    ev(3'b100, 2'h3);
    $display("events test done");
  endtask : t_events
  task automatic test_done;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    t_status();
    t_map();
    t_flags();
    t_events();
    test_done();
  end
  // whole run needs well under 1000 cycles
  initial begin
    #40000;
    bad_count++;
    test_done();
  end
endmodule : tb_top
